/* File: core/dao_defines.svh */
`ifndef DAO_DEFINES_SVH
`define DAO_DEFINES_SVH

`define DAO_LATENCY 5
`define DAO_WORD_W 12
`define DAO_CNT_W 16

`define DAO_OFF_CTRL 8'h00
`define DAO_OFF_STATE 8'h04
`define DAO_OFF_IRQ_STS 8'h08
`define DAO_OFF_IRQ_MASK 8'h0c
`define DAO_OFF_LAST_A 8'h10
`define DAO_OFF_LAST_B 8'h14
`define DAO_OFF_CNT_A 8'h18
`define DAO_OFF_CNT_B 8'h1c

`define DAO_CTRL_RUN_BIT 0
`define DAO_CTRL_RST 1'h1
`define DAO_MASK_RST 5'h00
`define DAO_STS_RST 5'h00
`define DAO_CNT_RST 16'h0000

`define DAO_EV_W 5
`define DAO_EV_WORD_A 0
`define DAO_EV_WORD_B 1
`define DAO_EV_RANGE_A 2
`define DAO_EV_RANGE_B 3
`define DAO_EV_MODE 4

`define DAO_ST_PWR_A_LSB 0
`define DAO_ST_PWR_B_LSB 4
`define DAO_ST_SWAP_BIT 8
`define DAO_ST_TWOS_BIT 9
`define DAO_ST_STAB_BIT 10

`define DAO_MODE_GND 2'h0
`define DAO_MODE_THIRD 2'h1
`define DAO_MODE_TWO_THIRDS 2'h2
`define DAO_MODE_FULL 2'h3

`define DAO_PINS_RST 9'h030
`define DAO_CODE_MAX 12'hfff
`define DAO_CODE_MIN 12'h000

`endif

/* File: core/dao_output_control.sv */
`timescale 1ns/1ns
`include "dao_defines.svh"

module dao_output_control #(
  parameter int LATENCY = `DAO_LATENCY
) (
  input wire logic clk, // 10 MHz system clock
  input wire logic rst_b, // Async reset, active low
  input wire logic ce, // Clock enable, freezes all state
  input wire logic hsel, // AHB slave select
  input wire logic [31:0] haddr, // AHB address
  input wire logic [1:0] htrans, // AHB transfer type
  input wire logic hwrite, // AHB write
  input wire logic [2:0] hsize, // AHB size, word only
  input wire logic [31:0] hwdata, // AHB write data
  input wire logic hready, // AHB bus ready
  output logic hreadyout, // AHB slave ready
  output logic hresp, // AHB response, always OKAY
  output logic [31:0] hrdata, // AHB read data
  input wire logic chan_a_sample_clock, // Channel A sample clock pin
  input wire logic chan_b_sample_clock, // Channel B sample clock pin
  input wire logic chan_a_power_down, // Channel A shutdown pin
  input wire logic chan_b_power_down, // Channel B shutdown pin
  input wire logic chan_a_output_enable_n, // Channel A output enable, low
  input wire logic chan_b_output_enable_n, // Channel B output enable, low
  input wire logic output_swap_select, // High: straight, low: swapped
  input wire logic [1:0] mode_level, // Four-level mode pin, coded
  input wire logic [`DAO_WORD_W-1:0] chan_a_code, // Channel A quantizer code
  input wire logic chan_a_over, // Channel A above range
  input wire logic chan_a_under, // Channel A below range
  input wire logic [`DAO_WORD_W-1:0] chan_b_code, // Channel B quantizer code
  input wire logic chan_b_over, // Channel B above range
  input wire logic chan_b_under, // Channel B below range
  output logic [`DAO_WORD_W-1:0] bus_a_data, // Bus A word
  output logic bus_a_range_flag, // Bus A range flag
  output logic bus_a_oe, // Bus A drive enable, high drives
  output logic [`DAO_WORD_W-1:0] bus_b_data, // Bus B word
  output logic bus_b_range_flag, // Bus B range flag
  output logic bus_b_oe, // Bus B drive enable, high drives
  output logic duty_stabilizer_on, // Clock duty stabilizer enable
  output logic irq // Level interrupt
);

  function automatic dao_pkg::dao_pwr_e pwr_of(input logic pd, input logic oe_n);
    case ({pd, oe_n})
      2'b00: pwr_of = dao_pkg::DAO_PWR_NORMAL;
      2'b01: pwr_of = dao_pkg::DAO_PWR_HIZ;
      2'b10: pwr_of = dao_pkg::DAO_PWR_NAP;
      default: pwr_of = dao_pkg::DAO_PWR_SLEEP;
    endcase
  endfunction

  function automatic logic twos_of(input logic [1:0] mode);
    case (mode)
      `DAO_MODE_GND: twos_of = 1'b0;
      `DAO_MODE_THIRD: twos_of = 1'b0;
      `DAO_MODE_TWO_THIRDS: twos_of = 1'b1;
      default: twos_of = 1'b1;
    endcase
  endfunction

  function automatic logic stab_of(input logic [1:0] mode);
    case (mode)
      `DAO_MODE_GND: stab_of = 1'b0;
      `DAO_MODE_THIRD: stab_of = 1'b1;
      `DAO_MODE_TWO_THIRDS: stab_of = 1'b1;
      default: stab_of = 1'b0;
    endcase
  endfunction

  function automatic dao_pkg::dao_word_s clamp(input logic [`DAO_WORD_W-1:0] code, input logic over,
                                               input logic under);
    clamp.flag = over | under;
    clamp.code = over ? `DAO_CODE_MAX : (under ? `DAO_CODE_MIN : code);
  endfunction

  // Inverting after the clamp keeps clamped codes at the coded extremes
  function automatic dao_pkg::dao_word_s fmt(input dao_pkg::dao_word_s w, input logic twos);
    fmt = w;
    fmt.code[`DAO_WORD_W-1] = w.code[`DAO_WORD_W-1] ^ twos;
  endfunction

  // Pin synchroniser: three stages, a level counts once stages two and three agree
  dao_pkg::dao_pins_s pins_in;
  dao_pkg::dao_pins_s s1_q;
  dao_pkg::dao_pins_s s2_q;
  dao_pkg::dao_pins_s s3_q;
  dao_pkg::dao_pins_s filt_q;
  dao_pkg::dao_pins_s filt_d;
  logic edge_a;
  logic edge_b;

  assign pins_in = '{swap: output_swap_select, mode: mode_level,
                     oe_n_b: chan_b_output_enable_n, oe_n_a: chan_a_output_enable_n,
                     pd_b: chan_b_power_down, pd_a: chan_a_power_down,
                     clk_b: chan_b_sample_clock, clk_a: chan_a_sample_clock};

  always_comb begin
    for (int i = 0; i < $bits(filt_d); i++) begin
      filt_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : filt_q[i];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s1_q <= `DAO_PINS_RST;
      s2_q <= `DAO_PINS_RST;
      s3_q <= `DAO_PINS_RST;
      filt_q <= `DAO_PINS_RST;
    end else if (ce) begin
      s1_q <= pins_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      filt_q <= filt_d;
    end
  end

  assign edge_a = filt_d.clk_a & ~filt_q.clk_a;
  assign edge_b = filt_d.clk_b & ~filt_q.clk_b;

  // Power state and conversion per channel
  dao_pkg::dao_pwr_e pwr_a_q;
  dao_pkg::dao_pwr_e pwr_b_q;
  dao_pkg::dao_pwr_e pwr_a_d;
  dao_pkg::dao_pwr_e pwr_b_d;
  logic run_q;
  logic conv_a;
  logic conv_b;
  logic adv_a;
  logic adv_b;
  dao_pkg::dao_word_s word_a;
  dao_pkg::dao_word_s word_b;
  logic stb_a;
  logic stb_b;

  always_comb begin
    pwr_a_d = pwr_of(filt_d.pd_a, filt_d.oe_n_a);
    pwr_b_d = pwr_of(filt_d.pd_b, filt_d.oe_n_b);
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pwr_a_q <= dao_pkg::DAO_PWR_HIZ;
      pwr_b_q <= dao_pkg::DAO_PWR_HIZ;
    end else if (ce) begin
      pwr_a_q <= pwr_a_d;
      pwr_b_q <= pwr_b_d;
    end
  end

  // Nap and sleep stop the pipe; high impedance alone keeps it running
  assign conv_a = run_q && (pwr_a_q == dao_pkg::DAO_PWR_NORMAL || pwr_a_q == dao_pkg::DAO_PWR_HIZ);
  assign conv_b = run_q && (pwr_b_q == dao_pkg::DAO_PWR_NORMAL || pwr_b_q == dao_pkg::DAO_PWR_HIZ);
  assign adv_a = edge_a & conv_a;
  assign adv_b = edge_b & conv_b;

  dao_pipe #(.WIDTH(`DAO_WORD_W + 1), .LAT(LATENCY)) u_pipe_a (
    .clk(clk),
    .rst_b(rst_b),
    .ce(ce),
    .adv(adv_a),
    .wdata(clamp(chan_a_code, chan_a_over, chan_a_under)),
    .rdata_q(word_a),
    .stb_q(stb_a)
  );

  dao_pipe #(.WIDTH(`DAO_WORD_W + 1), .LAT(LATENCY)) u_pipe_b (
    .clk(clk),
    .rst_b(rst_b),
    .ce(ce),
    .adv(adv_b),
    .wdata(clamp(chan_b_code, chan_b_over, chan_b_under)),
    .rdata_q(word_b),
    .stb_q(stb_b)
  );

  // Output buses
  dao_pkg::dao_word_s bus_a_q;
  dao_pkg::dao_word_s bus_b_q;
  dao_pkg::dao_word_s bus_a_d;
  dao_pkg::dao_word_s bus_b_d;
  logic oe_a_q;
  logic oe_b_q;
  logic oe_a_d;
  logic oe_b_d;
  logic twos_q;
  logic stab_q;
  logic drv_a;
  logic drv_b;

  assign drv_a = (pwr_a_q == dao_pkg::DAO_PWR_NORMAL);
  assign drv_b = (pwr_b_q == dao_pkg::DAO_PWR_NORMAL);

  always_comb begin
    if (filt_q.swap) begin
      bus_a_d = fmt(word_a, twos_q);
      bus_b_d = fmt(word_b, twos_q);
      oe_a_d = drv_a;
      oe_b_d = drv_b;
    end else begin
      bus_a_d = fmt(word_b, twos_q);
      bus_b_d = fmt(word_a, twos_q);
      oe_a_d = drv_b;
      oe_b_d = drv_a;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bus_a_q <= '0;
      bus_b_q <= '0;
      oe_a_q <= 1'b0;
      oe_b_q <= 1'b0;
      twos_q <= 1'b0;
      stab_q <= 1'b0;
    end else if (ce) begin
      bus_a_q <= bus_a_d;
      bus_b_q <= bus_b_d;
      oe_a_q <= oe_a_d;
      oe_b_q <= oe_b_d;
      twos_q <= twos_of(filt_q.mode);
      stab_q <= stab_of(filt_q.mode);
    end
  end

  assign bus_a_data = bus_a_q.code;
  assign bus_a_range_flag = bus_a_q.flag;
  assign bus_a_oe = oe_a_q;
  assign bus_b_data = bus_b_q.code;
  assign bus_b_range_flag = bus_b_q.flag;
  assign bus_b_oe = oe_b_q;
  assign duty_stabilizer_on = stab_q;

  // AHB-Lite slave: writes take no wait, reads one wait so read data come from a flop
  dao_pkg::dao_bus_req_s req_q;
  dao_pkg::dao_bus_req_s req_d;
  logic take;
  logic hready_q;
  logic hready_d;
  logic [31:0] hrdata_q;
  logic [31:0] hrdata_d;
  logic run_d;
  logic [`DAO_EV_W-1:0] mask_q;
  logic [`DAO_EV_W-1:0] mask_d;
  logic [`DAO_EV_W-1:0] sts_q;
  logic [`DAO_EV_W-1:0] sts_d;
  logic [`DAO_EV_W-1:0] clr;
  logic [`DAO_EV_W-1:0] ev;
  logic [`DAO_CNT_W-1:0] cnt_a_q;
  logic [`DAO_CNT_W-1:0] cnt_b_q;
  logic [`DAO_CNT_W-1:0] cnt_a_d;
  logic [`DAO_CNT_W-1:0] cnt_b_d;
  logic irq_q;
  logic [31:0] state_word;

  assign take = hsel & hready & htrans[1];

  assign state_word = {21'h000000, stab_q, twos_q, filt_q.swap, pwr_b_q, pwr_a_q};

  always_comb begin
    ev = '0;
    ev[`DAO_EV_WORD_A] = stb_a;
    ev[`DAO_EV_WORD_B] = stb_b;
    ev[`DAO_EV_RANGE_A] = stb_a & word_a.flag;
    ev[`DAO_EV_RANGE_B] = stb_b & word_b.flag;
    ev[`DAO_EV_MODE] = (filt_d.mode != filt_q.mode);
  end

  always_comb begin
    req_d.rd = take & ~hwrite;
    req_d.wr = take & hwrite;
    req_d.mapped = (haddr[31:8] == 24'h000000) && (haddr[1:0] == 2'h0);
    req_d.addr = haddr[7:0];
    hready_d = ~(take & ~hwrite);
    hrdata_d = hrdata_q;
    run_d = run_q;
    mask_d = mask_q;
    clr = '0;
    cnt_a_d = stb_a ? cnt_a_q + 16'h0001 : cnt_a_q;
    cnt_b_d = stb_b ? cnt_b_q + 16'h0001 : cnt_b_q;
    if (req_q.rd) begin
      hrdata_d = 32'h00000000;
      if (req_q.mapped) begin
        case (req_q.addr)
          `DAO_OFF_CTRL: hrdata_d = {31'h00000000, run_q};
          `DAO_OFF_STATE: hrdata_d = state_word;
          `DAO_OFF_IRQ_STS: hrdata_d = {27'h0000000, sts_q};
          `DAO_OFF_IRQ_MASK: hrdata_d = {27'h0000000, mask_q};
          `DAO_OFF_LAST_A: hrdata_d = {19'h00000, word_a};
          `DAO_OFF_LAST_B: hrdata_d = {19'h00000, word_b};
          `DAO_OFF_CNT_A: hrdata_d = {16'h0000, cnt_a_q};
          `DAO_OFF_CNT_B: hrdata_d = {16'h0000, cnt_b_q};
          default: hrdata_d = 32'h00000000;
        endcase
      end
    end
    if (req_q.wr && req_q.mapped) begin
      case (req_q.addr)
        `DAO_OFF_CTRL: run_d = hwdata[`DAO_CTRL_RUN_BIT];
        `DAO_OFF_IRQ_STS: clr = hwdata[`DAO_EV_W-1:0];
        `DAO_OFF_IRQ_MASK: mask_d = hwdata[`DAO_EV_W-1:0];
        `DAO_OFF_CNT_A: cnt_a_d = `DAO_CNT_RST;
        `DAO_OFF_CNT_B: cnt_b_d = `DAO_CNT_RST;
        default: run_d = run_q;
      endcase
    end
    // A new event beats a clear in the same cycle
    sts_d = (sts_q & ~clr) | ev;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      req_q <= '0;
      hready_q <= 1'b1;
      hrdata_q <= 32'h00000000;
      run_q <= `DAO_CTRL_RST;
      mask_q <= `DAO_MASK_RST;
      sts_q <= `DAO_STS_RST;
      cnt_a_q <= `DAO_CNT_RST;
      cnt_b_q <= `DAO_CNT_RST;
      irq_q <= 1'b0;
    end else if (ce) begin
      req_q <= req_d;
      hready_q <= hready_d;
      hrdata_q <= hrdata_d;
      run_q <= run_d;
      mask_q <= mask_d;
      sts_q <= sts_d;
      cnt_a_q <= cnt_a_d;
      cnt_b_q <= cnt_b_d;
      irq_q <= |(sts_q & mask_q);
    end
  end

  assign hreadyout = hready_q;
  assign hresp = 1'b0 & hready_q;
  assign hrdata = hrdata_q;
  assign irq = irq_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b || !ce);

  a_edge_own_clock: assert property (adv_a |-> s2_q.clk_a && s3_q.clk_a && !filt_q.clk_a)
    else $error("channel A advanced without its own edge");
  a_swap_high_route: assert property (filt_q.swap |=>
      bus_a_q.flag == $past(word_a.flag) && bus_b_q.flag == $past(word_b.flag))
    else $error("straight routing wrong");
  a_swap_low_route: assert property (!filt_q.swap |=>
      bus_a_q.flag == $past(word_b.flag) && bus_b_q.flag == $past(word_a.flag))
    else $error("swapped routing wrong");
  a_normal_drive: assert property (pwr_a_q == dao_pkg::DAO_PWR_NORMAL && filt_q.swap |=> bus_a_oe)
    else $error("normal channel not driving");
  a_hiz_converts: assert property (pwr_b_q == dao_pkg::DAO_PWR_HIZ && run_q && edge_b && !filt_q.swap
      |-> adv_b ##1 !bus_a_oe)
    else $error("hi-z channel stopped or drove");
  a_nap_idle: assert property (pwr_b_q == dao_pkg::DAO_PWR_NAP && filt_q.swap |-> !adv_b ##1 !bus_b_oe)
    else $error("nap channel active");
  a_sleep_idle: assert property (pwr_b_q == dao_pkg::DAO_PWR_SLEEP && !filt_q.swap
      |-> !adv_b ##1 !bus_a_oe)
    else $error("sleep channel active");
  a_chan_apart: assert property ($stable(filt_q.pd_a) && $stable(filt_q.oe_n_a) |-> $stable(pwr_a_q))
    else $error("channel A state moved by other pins");
  a_mode_third: assert property (filt_q.mode == `DAO_MODE_THIRD |=> stab_q && !twos_q)
    else $error("mode level one decode wrong");
  a_mode_full: assert property (filt_q.mode == `DAO_MODE_FULL |=> !stab_q && twos_q)
    else $error("mode level three decode wrong");
  a_mode_both_buses: assert property (twos_q && filt_q.swap |=>
      bus_a_q.code[11] != $past(word_a.code[11]) && bus_b_q.code[11] != $past(word_b.code[11]))
    else $error("coding not shared by both buses");
  a_twos_msb_only: assert property (twos_q && filt_q.swap |=> bus_a_q.code[10:0] == $past(word_a.code[10:0]))
    else $error("two's complement touched low bits");
  a_range_flag_out: assert property (stb_a && word_a.flag && filt_q.swap |=> bus_a_range_flag)
    else $error("range flag lost");
  a_read_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");

  c_swap_flip: cover property ($changed(filt_q.swap));
  c_nap_b: cover property (pwr_b_q == dao_pkg::DAO_PWR_NAP);
  c_irq_rise: cover property ($rose(irq_q));
  c_both_words: cover property (stb_a && stb_b);

endmodule

/* File: core/dao_pipe.sv */
`timescale 1ns/1ns
`include "dao_defines.svh"

module dao_pipe #(
  parameter int WIDTH = `DAO_WORD_W + 1,
  parameter int LAT = `DAO_LATENCY
) (
  input wire logic clk, // System clock
  input wire logic rst_b, // Async reset, active low
  input wire logic ce, // Clock enable
  input wire logic adv, // One sample clock edge
  input wire logic [WIDTH-1:0] wdata, // Word taken at this edge
  output logic [WIDTH-1:0] rdata_q, // Word from LAT edges ago
  output logic stb_q // Pulse: rdata_q renewed
);

  logic [WIDTH-1:0] mem_q [LAT];
  logic [WIDTH-1:0] mem_d [LAT];
  logic [LAT-1:0] vld_q;
  logic [LAT-1:0] vld_d;
  logic [WIDTH-1:0] rdata_d;
  logic stb_d;

  // Stages move only on sample edges, so latency is in sample clocks
  always_comb begin
    mem_d = mem_q;
    vld_d = vld_q;
    rdata_d = rdata_q;
    stb_d = 1'b0;
    if (adv) begin
      mem_d[0] = wdata;
      vld_d[0] = 1'b1;
      for (int i = 1; i < LAT; i++) begin
        mem_d[i] = mem_q[i-1];
        vld_d[i] = vld_q[i-1];
      end
      rdata_d = mem_q[LAT-1];
      stb_d = vld_q[LAT-1];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < LAT; i++) begin
        mem_q[i] <= '0;
      end
      vld_q <= '0;
      rdata_q <= '0;
      stb_q <= 1'b0;
    end else if (ce) begin
      mem_q <= mem_d;
      vld_q <= vld_d;
      rdata_q <= rdata_d;
      stb_q <= stb_d;
    end
  end

  logic [3:0] fill_q;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fill_q <= 4'h0;
    end else if (ce && adv && fill_q < 4'(LAT)) begin
      fill_q <= fill_q + 4'h1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b || !ce);

  a_pipe_no_early: assert property (adv && fill_q < 4'(LAT) |=> !stb_q)
    else $error("pipe word out before latency");
  a_pipe_word_out: assert property (adv && fill_q == 4'(LAT) |=> stb_q)
    else $error("pipe word missing after latency");
  c_pipe_first_word: cover property (adv && fill_q == 4'(LAT) ##1 stb_q);

endmodule

/* File: core/dao_pkg.sv */
`include "dao_defines.svh"

package dao_pkg;

  typedef enum logic [3:0] {
    DAO_PWR_NORMAL = 4'h1,
    DAO_PWR_HIZ = 4'h2,
    DAO_PWR_NAP = 4'h4,
    DAO_PWR_SLEEP = 4'h8
  } dao_pwr_e;

  typedef struct packed {
    logic flag;
    logic [`DAO_WORD_W-1:0] code;
  } dao_word_s;

  typedef struct packed {
    logic swap;
    logic [1:0] mode;
    logic oe_n_b;
    logic oe_n_a;
    logic pd_b;
    logic pd_a;
    logic clk_b;
    logic clk_a;
  } dao_pins_s;

  typedef struct packed {
    logic rd;
    logic wr;
    logic mapped;
    logic [7:0] addr;
  } dao_bus_req_s;

endpackage

/* File: verif/dao_capture.sv */
`timescale 1ns/1ns
`include "dao_defines.svh"

module dao_capture (
  input wire logic clk, // System clock
  input wire logic rst_b, // Async reset, active low
  input wire logic [`DAO_WORD_W-1:0] data, // Bus word from the device
  input wire logic flag, // Range flag from the device
  input wire logic oe, // Device drives the bus
  output logic [`DAO_WORD_W:0] seen // Level on the wires
);
  logic [`DAO_WORD_W:0] last_q;
  logic [`DAO_WORD_W:0] last_d;

  // A released bus shows the inverse of the last driven word, never the stale word
  assign seen = oe ? {flag, data} : ~last_q;

  always_comb begin
    last_d = oe ? {flag, data} : last_q;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      last_q <= '0;
    end else begin
      last_q <= last_d;
    end
  end
endmodule

/* File: verif/dual_adc_output_control_test.sv */
`timescale 1ns/1ns
`include "dao_defines.svh"

module dual_adc_output_control_test;
  logic clk, rst_b, hsel, hwrite, hreadyout, hresp, irq, stab;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans, mode_level, fa, fb, bst, md;
  logic clk_a, clk_b, pd_a, pd_b, oen_a, oen_b, swap, over_a, under_a, over_b, under_b;
  logic [11:0] code_a, code_b, dat_a, dat_b;
  logic flag_a, flag_b, oe_a, oe_b, expa, expb;
  logic [12:0] seen_a, seen_b, wa, wb;
  logic [12:0] qa[$];
  logic [12:0] qb[$];
  int mismatches, num_checks, cycles, i;

  dao_output_control dut_u (.clk(clk), .rst_b(rst_b), .ce(1'b1), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .chan_a_sample_clock(clk_a), .chan_b_sample_clock(clk_b), .chan_a_power_down(pd_a),
    .chan_b_power_down(pd_b), .chan_a_output_enable_n(oen_a), .chan_b_output_enable_n(oen_b),
    .output_swap_select(swap), .mode_level(mode_level), .chan_a_code(code_a), .chan_a_over(over_a),
    .chan_a_under(under_a), .chan_b_code(code_b), .chan_b_over(over_b), .chan_b_under(under_b),
    .bus_a_data(dat_a), .bus_a_range_flag(flag_a), .bus_a_oe(oe_a), .bus_b_data(dat_b),
    .bus_b_range_flag(flag_b), .bus_b_oe(oe_b), .duty_stabilizer_on(stab), .irq(irq));

  dao_capture cap_a_u (.clk(clk), .rst_b(rst_b), .data(dat_a), .flag(flag_a), .oe(oe_a), .seen(seen_a));
  dao_capture cap_b_u (.clk(clk), .rst_b(rst_b), .data(dat_b), .flag(flag_b), .oe(oe_b), .seen(seen_b));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task complete_run;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // Whole run is about 670 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      complete_run;
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task ahb(input logic [7:0] a, input logic w, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    rd = hrdata;
    chk(32'(hresp), 32'h0);
  endtask

  function logic [12:0] clampw(input logic [11:0] c, input logic [1:0] y);
    clampw = {|y, y[1] ? `DAO_CODE_MAX : (y[0] ? `DAO_CODE_MIN : c)};
  endfunction

  function logic [12:0] fmt(input logic [12:0] w, input logic t);
    fmt = {w[12], w[11] ^ t, w[10:0]};
  endfunction

  // Pins settle before the edge; codes held until the edge is seen
  task pulse(input logic [11:0] xa, xb, input logic [1:0] ya, yb, input logic cka, ckb);
    code_a <= xa;
    over_a <= ya[1];
    under_a <= ya[0];
    code_b <= xb;
    over_b <= yb[1];
    under_b <= yb[0];
    repeat (6) @(posedge clk);
    clk_a <= cka;
    clk_b <= ckb;
    repeat (8) @(posedge clk);
    clk_a <= 1'b0;
    clk_b <= 1'b0;
    repeat (8) @(posedge clk);
    if (cka) qa.push_back(clampw(xa, ya));
    if (ckb && !pd_b) qb.push_back(clampw(xb, yb));
    if (qa.size() > `DAO_LATENCY) wa = qa.pop_front();
    if (qb.size() > `DAO_LATENCY) wb = qb.pop_front();
  endtask

  initial begin
    rst_b = 1'b0;
    {hsel, hwrite, clk_a, clk_b, pd_a, pd_b, oen_a, oen_b} = 8'h00;
    {over_a, under_a, over_b, under_b} = 4'h0;
    haddr = 32'h0;
    hwdata = 32'h0;
    htrans = 2'h0;
    swap = 1'b1;
    mode_level = 2'h0;
    code_a = 12'h000;
    code_b = 12'h000;
    mismatches = 0;
    num_checks = 0;
    cycles = 0;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    ahb(`DAO_OFF_CTRL, 1'b0, 32'h0);
    chk(rd, 32'h1);
    ahb(`DAO_OFF_IRQ_MASK, 1'b0, 32'h0);
    chk(rd, 32'h0);
    ahb(8'h20, 1'b1, 32'hffffffff);
    ahb(8'h20, 1'b0, 32'h0);
    chk(rd, 32'h0);
    for (i = 0; i < 5; i++) pulse(12'(i * 16 + 5), ~12'(i * 16 + 5), 2'h0, 2'h0, 1'b1, 1'b1);
    ahb(`DAO_OFF_IRQ_STS, 1'b0, 32'h0);
    chk(rd & 32'hf, 32'h0);
    pulse(12'h7ff, 12'h800, 2'h0, 2'h0, 1'b1, 1'b1);
    chk(32'(seen_a), 32'h005);
    chk(32'(seen_b), 32'hffa);
    ahb(`DAO_OFF_LAST_A, 1'b0, 32'h0);
    chk(rd, 32'h005);
    chk(32'(irq), 32'h0);
    ahb(`DAO_OFF_IRQ_STS, 1'b0, 32'h0);
    chk(rd & 32'h1, 32'h1);
    ahb(`DAO_OFF_IRQ_MASK, 1'b1, 32'h1);
    repeat (2) @(posedge clk);
    chk(32'(irq), 32'h1);
    ahb(`DAO_OFF_IRQ_STS, 1'b1, 32'h1);
    repeat (2) @(posedge clk);
    chk(32'(irq), 32'h0);
    ahb(`DAO_OFF_IRQ_MASK, 1'b1, 32'h0);
    // Every mode, swap setting and channel B power state, with clamps
    for (i = 0; i < 16; i++) begin
      bst = 2'(i >> 1);
      md = 2'(i >> 2);
      pd_b <= bst[1];
      oen_b <= bst[0];
      mode_level <= md;
      swap <= i[0];
      fa = (i % 5 == 3) ? 2'b10 : ((i % 5 == 4) ? 2'b01 : 2'b00);
      fb = (i % 3 == 1) ? 2'b01 : 2'b00;
      pulse(12'(165 + 273 * i), 12'(3840 - 241 * i), fa, fb, 1'b1, i % 4 != 3);
      expa = i[0] | (bst == 2'h0);
      expb = ~i[0] | (bst == 2'h0);
      chk(32'(oe_a), 32'(expa));
      chk(32'(oe_b), 32'(expb));
      if (expa) chk(32'(seen_a), 32'(fmt(i[0] ? wa : wb, md[1])));
      if (expb) chk(32'(seen_b), 32'(fmt(i[0] ? wb : wa, md[1])));
      chk(32'(stab), 32'((md == 2'h1) || (md == 2'h2)));
      ahb(`DAO_OFF_STATE, 1'b0, 32'h0);
      chk(rd, {21'h0, (md == 2'h1) || (md == 2'h2), md[1], i[0], 4'h1 << bst, 4'h1});
    end
    // Channel A took 22 samples, so 17 words have left its pipe
    ahb(`DAO_OFF_CNT_A, 1'b0, 32'h0);
    chk(rd, 32'h11);
    // Run off: a sample edge is ignored and the pipe keeps its words
    ahb(`DAO_OFF_CTRL, 1'b1, 32'h0);
    clk_a <= 1'b1;
    repeat (8) @(posedge clk);
    clk_a <= 1'b0;
    repeat (8) @(posedge clk);
    ahb(`DAO_OFF_CNT_A, 1'b0, 32'h0);
    chk(rd, 32'h11);
    ahb(`DAO_OFF_CTRL, 1'b1, 32'h1);
    // Interleaved on bus A: swap select and both sample clocks move as one signal
    pd_b <= 1'b0;
    oen_b <= 1'b0;
    mode_level <= 2'h0;
    swap <= 1'b0;
    for (i = 0; i < 3; i++) begin
      code_a <= 12'(i * 300 + 7);
      code_b <= 12'(i * 200 + 9);
      repeat (6) @(posedge clk);
      {swap, clk_a, clk_b} <= 3'h7;
      qa.push_back(clampw(code_a, 2'h0));
      qb.push_back(clampw(code_b, 2'h0));
      wa = qa.pop_front();
      wb = qb.pop_front();
      repeat (8) @(posedge clk);
      chk(32'(seen_a), 32'(wa));
      {swap, clk_a, clk_b} <= 3'h0;
      repeat (8) @(posedge clk);
      chk(32'(seen_a), 32'(wb));
    end
    complete_run;
  end
endmodule
